// *** logic/mac_regs_defs.svh ***
`ifndef MAC_REGS_DEFS_SVH
`define MAC_REGS_DEFS_SVH

`define OFS_MGMT_READ_DATA   8'h24
`define OFS_MGMT_WRITE_DATA  8'h28
`define OFS_TX_DESC_PTR_LOW  8'h2c
`define OFS_TX_DESC_PTR_HIGH 8'h30
`define OFS_RX_DESC_PTR_LOW  8'h34
`define OFS_RX_DESC_PTR_HIGH 8'h38
`define REG_RESET_VAL        16'h0000
`define PTR_LOW_WMASK        16'hfffe
`define REQ_WRITE_BIT        14
`define REQ_READ_BIT         13

`endif

// *** logic/mac_regs_pkg.sv ***
`default_nettype none
package mac_regs_pkg;
    // Register access from the processor I/O port
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } io_req_s;

    // Ring pointer update from the DMA engine
    typedef struct packed {
        logic        load;
        logic [31:0] next_ptr;
    } ring_upd_s;

    typedef enum logic [2:0] {
        MG_IDLE  = 3'b001,
        MG_READ  = 3'b010,
        MG_WRITE = 3'b100
    } mgmt_state_e;
endpackage
`default_nettype wire

// *** logic/mac_mdio_data_and_desc_ptr_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mac_regs_defs.svh"
module mac_mdio_data_and_desc_ptr_regs
    import mac_regs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    input  wire io_req_s     io_req,
    output logic [15:0]      io_rdata,
    output logic             io_rvalid,
    input  wire logic        mgmt_read_request,
    input  wire logic        mgmt_write_request,
    input  wire logic        mgmt_done,
    input  wire logic [15:0] mgmt_rd_value,
    output logic [15:0]      mgmt_wr_value,
    output logic             mgmt_read_clear,
    output logic             mgmt_write_clear,
    input  wire ring_upd_s   tx_upd,
    input  wire ring_upd_s   rx_upd,
    output logic [31:0]      tx_ring_pointer,
    output logic [31:0]      rx_ring_pointer
);

    logic [15:0] rd_data_r,  rd_data_nxt;
    logic [15:0] wr_data_r,  wr_data_nxt;
    mgmt_state_e state_r,    state_nxt;
    logic        rclr_r,     rclr_nxt;
    logic        wclr_r,     wclr_nxt;
    logic [15:0] rdata_r,    rdata_nxt;
    logic        rvalid_r,   rvalid_nxt;

    // Ring storage, index 0 transmit, index 1 receive
    logic [15:0] ring_lo_r   [2];
    logic [15:0] ring_lo_nxt [2];
    logic [15:0] ring_hi_r   [2];
    logic [15:0] ring_hi_nxt [2];
    ring_upd_s   ring_upd    [2];

    // Both update ports gathered so one loop serves both rings
    assign ring_upd[0] = tx_upd;
    assign ring_upd[1] = rx_upd;

    // Management transfer tracking; request bits live in the command register
    // Only the transfer state and the clear pulses live in this group
    // A request still high after its clear would start a second transfer
    always_comb
    begin
        state_nxt   = state_r;
        rclr_nxt    = 1'b0;
        wclr_nxt    = 1'b0;
        case (state_r)
            MG_IDLE:
            begin
                // Write wins if both are raised together
                if (mgmt_write_request)
                    state_nxt = MG_WRITE;
                else if (mgmt_read_request)
                    state_nxt = MG_READ;
            end
            MG_READ:
            begin
                if (mgmt_done)
                begin
                    rclr_nxt    = 1'b1;
                    state_nxt   = MG_IDLE;
                end
            end
            MG_WRITE:
            begin
                if (mgmt_done)
                begin
                    wclr_nxt  = 1'b1;
                    state_nxt = MG_IDLE;
                end
            end
            default: state_nxt = MG_IDLE;
        endcase
    end

    // Transfer state flops, frozen while clk_en is low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= MG_IDLE;
            rclr_r  <= 1'b0;
            wclr_r  <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r <= state_nxt;
            rclr_r  <= rclr_nxt;
            wclr_r  <= wclr_nxt;
        end
    end

    // Read-data capture; only a finishing read may load it
    // Data arriving while idle or writing is stray and dropped
    always_comb
    begin
        rd_data_nxt = rd_data_r;
        if (state_r == MG_READ && mgmt_done)
            rd_data_nxt = mgmt_rd_value;
    end

    // Read-data flop; software has no write path into it
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data_r <= `REG_RESET_VAL;
        else if (clk_en)
            rd_data_r <= rd_data_nxt;
    end

    // Write-data register; writes to the read-data offset fall through
    always_comb
    begin
        wr_data_nxt = wr_data_r;
        if (io_req.wr && io_req.addr == `OFS_MGMT_WRITE_DATA)
            wr_data_nxt = io_req.wdata;
    end

    // Write-data flop; the serial engine reads it straight from here
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            wr_data_r <= `REG_RESET_VAL;
        else if (clk_en)
            wr_data_r <= wr_data_nxt;
    end

    // One pointer pair per ring, same logic for transmit and receive
    for (genvar g = 0; g < 2; g++)
    begin : g_ring
        localparam logic [7:0] LO_OFS = (g == 0) ? `OFS_TX_DESC_PTR_LOW : `OFS_RX_DESC_PTR_LOW;
        localparam logic [7:0] HI_OFS = (g == 0) ? `OFS_TX_DESC_PTR_HIGH : `OFS_RX_DESC_PTR_HIGH;

        // Frame-end update wins over a same-cycle software write
        // Software is trusted to write only with the ring's enable clear
        always_comb
        begin
            ring_lo_nxt[g] = ring_lo_r[g];
            ring_hi_nxt[g] = ring_hi_r[g];
            if (io_req.wr)
            begin
                if (io_req.addr == LO_OFS)
                    ring_lo_nxt[g] = io_req.wdata & `PTR_LOW_WMASK;
                else if (io_req.addr == HI_OFS)
                    ring_hi_nxt[g] = io_req.wdata;
            end
            if (ring_upd[g].load)
            begin
                ring_hi_nxt[g] = ring_upd[g].next_ptr[31:16];
                ring_lo_nxt[g] = ring_upd[g].next_ptr[15:0] & `PTR_LOW_WMASK;
            end
        end

        // Pointer flops; bit 0 is masked on every load path
        always_ff @(posedge mclk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                ring_lo_r[g] <= `REG_RESET_VAL;
                ring_hi_r[g] <= `REG_RESET_VAL;
            end
            else if (clk_en)
            begin
                ring_lo_r[g] <= ring_lo_nxt[g];
                ring_hi_r[g] <= ring_hi_nxt[g];
            end
        end
    end

    // Read mux; unmapped offsets return zero
    // Answer comes one cycle after a request taken with clk_en high, so no wait state exists
    always_comb
    begin
        rvalid_nxt = io_req.rd;
        rdata_nxt  = `REG_RESET_VAL;
        if (io_req.rd)
        begin
            if (io_req.addr == `OFS_MGMT_READ_DATA)
                rdata_nxt = rd_data_r;
            else if (io_req.addr == `OFS_MGMT_WRITE_DATA)
                rdata_nxt = wr_data_r;
            else if (io_req.addr == `OFS_TX_DESC_PTR_LOW)
                rdata_nxt = ring_lo_r[0] & `PTR_LOW_WMASK;
            else if (io_req.addr == `OFS_TX_DESC_PTR_HIGH)
                rdata_nxt = ring_hi_r[0];
            else if (io_req.addr == `OFS_RX_DESC_PTR_LOW)
                rdata_nxt = ring_lo_r[1] & `PTR_LOW_WMASK;
            else if (io_req.addr == `OFS_RX_DESC_PTR_HIGH)
                rdata_nxt = ring_hi_r[1];
        end
    end

    // Answer flops; held while clk_en is low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_r  <= `REG_RESET_VAL;
            rvalid_r <= 1'b0;
        end
        else if (clk_en)
        begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // Outputs straight from flops
    assign io_rdata         = rdata_r;
    assign io_rvalid        = rvalid_r;
    assign mgmt_wr_value    = wr_data_r;
    assign mgmt_read_clear  = rclr_r;
    assign mgmt_write_clear = wclr_r;
    assign tx_ring_pointer  = {ring_hi_r[0], ring_lo_r[0]};
    assign rx_ring_pointer  = {ring_hi_r[1], ring_lo_r[1]};

endmodule
`default_nettype wire

// *** sim/mac_regs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module reg_checker
    import mac_regs_pkg::*;
(
    input wire logic        mclk, rst_n, clk_en, io_rvalid, mgmt_done,
    input wire logic        mgmt_read_request, mgmt_write_request, mgmt_read_clear, mgmt_write_clear,
    input wire io_req_s     io_req,
    input wire ring_upd_s   tx_upd, rx_upd,
    input wire logic [15:0] io_rdata, mgmt_rd_value, mgmt_wr_value,
    input wire logic [31:0] tx_ring_pointer, rx_ring_pointer
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Completion steps of a management transfer
    sequence rd_done_s; clk_en && mgmt_done && mgmt_read_request && !mgmt_write_request; endsequence
    sequence wr_done_s; clk_en && mgmt_done && mgmt_write_request; endsequence
    tx_bit_zero_a: assert property (tx_ring_pointer[0] == 1'b0) else $error("tx bit 0 set");
    rx_bit_zero_a: assert property (rx_ring_pointer[0] == 1'b0) else $error("rx bit 0 set");
    tx_low_read_a: assert property (clk_en && io_req.rd && io_req.addr == 8'h2c
        |=> io_rdata == $past(tx_ring_pointer[15:0])) else $error("tx low read");
    tx_update_a: assert property (clk_en && tx_upd.load
        |=> tx_ring_pointer == {$past(tx_upd.next_ptr[31:1]), 1'b0}) else $error("tx update");
    rx_update_a: assert property (clk_en && rx_upd.load
        |=> rx_ring_pointer == {$past(rx_upd.next_ptr[31:1]), 1'b0}) else $error("rx update");
    wdata_out_a: assert property (clk_en && io_req.wr && io_req.addr == 8'h28
        |=> mgmt_wr_value == $past(io_req.wdata)) else $error("write data");
    rd_clear_a: assert property (rd_done_s |=> mgmt_read_clear && !mgmt_write_clear) else $error("rd clear");
    wr_clear_a: assert property (wr_done_s |=> mgmt_write_clear && !mgmt_read_clear) else $error("wr clear");
    rx_low_read_a: assert property (clk_en && io_req.rd && io_req.addr == 8'h34
        |=> io_rdata == $past(rx_ring_pointer[15:0])) else $error("rx low read");
    freeze_hold_a: assert property (!clk_en |=> $stable(mgmt_wr_value) && $stable(tx_ring_pointer)
        && $stable(rx_ring_pointer) && $stable(io_rvalid)) else $error("clock enable freeze");
    reset_zero_a: assert property ($rose(rst_n) |-> tx_ring_pointer == 32'h0 &&
        rx_ring_pointer == 32'h0 && mgmt_wr_value == 16'h0) else $error("reset value");
endmodule
bind mac_mdio_data_and_desc_ptr_regs reg_checker u_chk (.*);
`default_nettype wire

// *** sim/phy_mgmt_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Serial engine and PHY: finishes a transfer DLY+1 cycles after the request
module phy_mgmt_model #(parameter int DLY = 6)
(
    input wire logic        mclk, rst_n, req,
    input wire logic [15:0] wr_value, rd_src,
    output logic            done,
    output logic [15:0]     rd_value, got_wr
);
    logic [7:0] cnt;
    // Data line toggles when not presenting, so stale values never match
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 8'h0; done <= 1'b0; rd_value <= 16'h0; got_wr <= 16'h0;
        end
        else
        begin
            done <= 1'b0;
            rd_value <= ~rd_value;
            cnt <= req ? cnt + 8'h1 : 8'h0;
            if (req && cnt == 8'(DLY))
            begin
                done <= 1'b1;
                rd_value <= rd_src;
                got_wr <= wr_value;
                cnt <= 8'h0;
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/mac_mdio_data_and_desc_ptr_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module mac_mdio_data_and_desc_ptr_regs_tb;
    import mac_regs_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, mgmt_read_request = 1'b0, mgmt_write_request = 1'b0;
    io_req_s     io_req = '0;
    ring_upd_s   tx_upd = '0, rx_upd = '0;
    logic [15:0] io_rdata, mgmt_wr_value, mgmt_rd_value, got_wr, rd_src = 16'h0;
    logic [31:0] tx_ring_pointer, rx_ring_pointer;
    logic        io_rvalid, mgmt_done, mgmt_read_clear, mgmt_write_clear;
    int          bad_count = 0, tests_run = 0, cyc = 0;
    mac_mdio_data_and_desc_ptr_regs dut (.*);
    phy_mgmt_model phy (.mclk(mclk), .rst_n(rst_n), .req(mgmt_read_request | mgmt_write_request),
        .wr_value(mgmt_wr_value), .rd_src(rd_src), .done(mgmt_done), .rd_value(mgmt_rd_value), .got_wr(got_wr));
    initial forever #2.5 mclk = ~mclk;
    // Hang guard, far above the fewer than a hundred cycles needed
    always @(posedge mclk) if (++cyc == 4000) begin bad_count++; results(); end
    task automatic chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp) begin bad_count++; $display("MISMATCH %0t got %h exp %h", $time, got, exp); end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk) io_req = '{1'b1, 1'b0, a, d};
        @(negedge mclk) io_req = '0;
    endtask
    // Answer is a one-cycle pulse, seen at the next falling edge
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge mclk) io_req = '{1'b0, 1'b1, a, 16'h0};
        @(negedge mclk) io_req = '0;
        chk({15'h0, io_rvalid, io_rdata}, {16'h1, e});
    endtask
    // Request level drops in the cycle its clear pulse shows
    task automatic mg(input logic w, input logic [15:0] v);
        int n;
        rd_src = v;
        @(negedge mclk) {mgmt_write_request, mgmt_read_request} = {w, !w};
        for (n = 0; n < 50 && !(mgmt_read_clear | mgmt_write_clear); n++) @(negedge mclk);
        chk({mgmt_read_clear, mgmt_write_clear}, {!w, w});
        {mgmt_write_request, mgmt_read_request} = 2'b00;
    endtask
    task results;
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge mclk);
        rst_n = 1'b1;
        for (int i = 0; i < 6; i++) rd(8'h24 + 8'(4 * i), 16'h0);
        $display("reset values done");
        wr(8'h28, 16'ha5c3); rd(8'h28, 16'ha5c3); chk(mgmt_wr_value, 16'ha5c3);
        wr(8'h24, 16'hffff); rd(8'h24, 16'h0); rd(8'h3c, 16'h0);
        wr(8'h2c, 16'hffff); wr(8'h30, 16'h1234); rd(8'h2c, 16'hfffe);
        chk(tx_ring_pointer, 32'h1234fffe);
        wr(8'h34, 16'h8001); wr(8'h38, 16'hbeef); rd(8'h34, 16'h8000);
        chk(rx_ring_pointer, 32'hbeef8000);
        $display("pointer access done");
        mg(1'b0, 16'h5a69); rd(8'h24, 16'h5a69);
        mg(1'b1, 16'h0); chk(got_wr, 16'ha5c3);
        $display("management done");
        @(negedge mclk) {tx_upd, rx_upd} = {1'b1, 32'h00010040, 1'b1, 32'h00020080};
        @(negedge mclk) {tx_upd, rx_upd} = '0;
        chk(tx_ring_pointer, 32'h00010040);
        chk(rx_ring_pointer, 32'h00020080);
        rd(8'h30, 16'h0001);
        $display("ring update done");
        @(negedge mclk) clk_en = 1'b0;
        wr(8'h28, 16'h1111);
        @(negedge mclk) clk_en = 1'b1;
        chk(mgmt_wr_value, 16'ha5c3);
        rd(8'h28, 16'ha5c3);
        $display("clock enable done");
        @(negedge mclk) rst_n = 1'b0;
        @(negedge mclk) rst_n = 1'b1;
        chk(tx_ring_pointer, 32'h0);
        chk(rx_ring_pointer, 32'h0);
        rd(8'h24, 16'h0);
        $display("second reset done");
        results();
    end
endmodule
`default_nettype wire
